// >>> common/shfl_defs.vh
/*
  constants for the sync-header-stream fec link receiver (host side).
  assumes 64b/66b blocks already block-aligned and descrambling done elsewhere.
*/
`ifndef SHFL_DEFS_VH
`define SHFL_DEFS_VH

// sync header mode select codes driven to the device
`define SHFL_SHM_CRC   2'h0
`define SHFL_SHM_FEC   2'h2

// parity generator
`define SHFL_PAR_W     26
`define SHFL_POLY      26'h0220211
`define SHFL_DATA_W    64

// multiblock framing
`define SHFL_MB_LAST   5'h1f
`define SHFL_PILOT     5'h01
`define SHFL_END_OF_EXT_MULTIBLOCK_FLAG_POS 9

// fifo
`define SHFL_FIFO_DEPTH 8

// buffer release states
`define SHFL_ST_IDLE   2'h0
`define SHFL_ST_WAIT   2'h1
`define SHFL_ST_BUF    2'h2
`define SHFL_ST_REL    2'h3

`endif

// >>> dv/shfl_dev_model.sv
/* device model: 64b/66b blocks with the fec sync header stream.
   assumes one block per cycle, held until the host takes it. */
`timescale 1ns/1ps
module shfl_dev_model (
  // clock and device pins
  input  wire        clk_sys,
  input  wire        link_enable,
  input  wire [1:0]  sync_header_mode_select,
  // faults and stalls
  input  wire        hold,
  input  wire        err_hdr,
  input  wire        err_pilot,
  input  wire        err_bit,
  input  wire        err_end_of_ext_multiblock_flag,
  // block stream
  output reg         blk_valid = 1'b0,
  output reg  [1:0]  blk_hdr = 2'h0,
  output reg  [63:0] blk_data = 64'h0,
  output reg  [4:0]  blk_idx = 5'h1f,
  input  wire        blk_ready
);
  reg [25:0] par;
  reg [25:0] run;
  reg [25:0] s;
  reg [31:0] st;
  reg [63:0] d;
  reg [4:0]  k;
  integer    i;
  always @(posedge clk_sys)
  begin
    if (link_enable !== 1'b1)
    begin
      par       <= 26'h0;
      blk_idx   <= 5'h1f;
      blk_valid <= 1'b0;
      blk_data  <= ~blk_data;
    end
    else if (!blk_valid || blk_ready)
    begin
      if (hold)
      begin
        // a stalled lane shows no stale block
        blk_valid <= 1'b0;
        blk_data  <= ~blk_data;
      end
      else
      begin
        k = blk_idx + 5'h1;
        s = (k == 5'h0) ? 26'h0 : run;
        st = 32'h0;
        for (i = 0; i < 27; i = i + 1)
          st[i] = (sync_header_mode_select == 2'h2) && par[(i < 22) ? 25 - i : 26 - i];
        st[22] = ~err_end_of_ext_multiblock_flag;
        st[31] = ~err_pilot;
        d = {$urandom, $urandom};
        for (i = 63; i >= 0; i = i - 1)
          s = {s[24:0], 1'b0} ^ ({26{d[i] ^ s[25]}} & 26'h0220211);
        run <= s;
        if (k == 5'h1f)
          par <= s;
        blk_hdr   <= err_hdr ? 2'h3 : {st[k], ~st[k]};
        blk_data  <= {d[63] ^ (err_bit && k == 5'h0), d[62:0]};
        blk_idx   <= k;
        blk_valid <= 1'b1;
      end
    end
  end
endmodule // shfl_dev_model

// >>> dv/shfl_rx_host_bench.sv
/* self-checking bench: host receiver against the device model.
   assumes the checker binds itself in its own file. */
`timescale 1ns/1ps
module shfl_rx_host_bench;
  // stimulus
  reg          clk_sys, local_ext_multiblock_clock_tick, out_ready;
  reg          sys_rst = 1'b1;
  reg          cmd_enable = 1'b0;
  reg          cmd_fec = 1'b0;
  reg  [3:0]   cmd_preemph = 4'h0;
  reg  [7:0]   cmd_rbd = 8'h0;
  reg          hold = 1'b0;
  reg          err_hdr = 1'b0;
  reg          err_pilot = 1'b0;
  reg          err_bit = 1'b0;
  reg          err_end_of_ext_multiblock_flag = 1'b0;
  // observed
  wire         link_enable, sysref_pulse, blk_valid, blk_ready, out_valid;
  wire         blk_lock, mb_lock, emb_lock, released, syndrome_valid, fec_error, realign_req;
  wire [1:0]   sync_header_mode_select, blk_hdr;
  wire [3:0]   serializer_preemphasis_level;
  wire [63:0]  blk_data, out_data;
  wire [4:0]   blk_idx;
  wire [25:0]  syndrome;
  // scoreboard
  logic [63:0] q[$];
  int          qk[$];
  int          n_mismatch, comparisons, cyc, n_zero, n_nz, n_ref, n_out, inj_cyc, t0, ro_mode, n_rr;
  bit          armed, synced;
  logic [25:0] exp_syn;
  logic [3:0]  pe;
  shfl_rx_host uut (
    .clk_sys, .sys_rst, .cmd_enable, .cmd_fec, .cmd_preemph, .cmd_rbd, .link_enable,
    .sync_header_mode_select, .serializer_preemphasis_level, .sysref_pulse, .local_ext_multiblock_clock_tick,
    .blk_valid, .blk_hdr, .blk_data, .blk_ready, .out_valid, .out_data, .out_ready, .blk_lock,
    .mb_lock, .emb_lock, .released, .syndrome, .syndrome_valid, .fec_error, .realign_req);
  shfl_dev_model dev (
    .clk_sys, .link_enable, .sync_header_mode_select, .hold, .err_hdr, .err_pilot,
    .err_bit, .err_end_of_ext_multiblock_flag, .blk_valid, .blk_hdr, .blk_data, .blk_idx, .blk_ready);
  task check(input logic [63:0] got, input logic [63:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task summarize;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // local clock edge every 32 cycles; release delay kept short of one period
  always @(negedge clk_sys)
  begin
    local_ext_multiblock_clock_tick <= (cyc % 32 == 7);
    out_ready <= (ro_mode == 2) ? ($urandom % 2 == 1) : (ro_mode == 1);
  end
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    n_ref = n_ref + (sysref_pulse === 1'b1);
    n_rr = n_rr + (realign_req === 1'b1);
    if (syndrome_valid === 1'b1)
      check(fec_error, syndrome !== 26'h0);
    if (released !== 1'b1)
      synced = 1'b0;
    if (blk_valid && blk_ready)
    begin
      q.push_back(blk_data);
      qk.push_back(blk_idx);
    end
    if (out_valid === 1'b1 && out_ready)
    begin
      while (!synced && q.size() > 1 && q[0] !== out_data)
      begin
        void'(q.pop_front());
        void'(qk.pop_front());
      end
      if (!synced)
        check(qk[0], 0);
      synced = 1'b1;
      check(out_data, q.pop_front());
      void'(qk.pop_front());
      n_out = n_out + 1;
    end
    if (syndrome_valid === 1'b1 && syndrome === 26'h0)
      n_zero = n_zero + 1;
    else if (syndrome_valid === 1'b1)
    begin
      n_nz = n_nz + 1;
      if (armed)
      begin
        check(syndrome, exp_syn);
        check(cyc - inj_cyc >= 58, 1'b1);
      end
    end
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0t timeout", $time);
      summarize;
    end
  end
  initial
  begin
    void'($urandom(90166));
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    pe = 4'($urandom);
    cmd_preemph = pe;
    cmd_rbd = 8'($urandom % 20);
    @(negedge clk_sys);
    check(sync_header_mode_select, 2'h0);
    cmd_fec = 1'b1;
    cmd_enable = 1'b1;
    @(negedge clk_sys);
    check(link_enable, 1'b1);
    check(sync_header_mode_select, 2'h2);
    check(serializer_preemphasis_level, pe);
    check(sysref_pulse, 1'b1);
    cmd_fec = 1'b0;
    cmd_preemph = ~pe;
    $display("test enable done");
    repeat (300) if (blk_lock !== 1'b1) @(negedge clk_sys);
    t0 = cyc;
    repeat (1000) if (mb_lock !== 1'b1) @(negedge clk_sys);
    check(mb_lock === 1'b1 && cyc - t0 >= 64, 1'b1);
    repeat (200) if (released !== 1'b1) @(negedge clk_sys);
    check(emb_lock & released, 1'b1);
    check({sync_header_mode_select, serializer_preemphasis_level}, {2'h2, pe});
    $display("test align done");
    // fifo held full with the far side stalled, then drained empty
    repeat (20) @(negedge clk_sys);
    check({blk_ready, out_valid}, 2'b01);
    hold = 1'b1;
    ro_mode = 2;
    repeat (60) @(negedge clk_sys);
    check(out_valid === 1'b0 && n_out >= 8, 1'b1);
    hold = 1'b0;
    ro_mode = 1;
    $display("test buffer done");
    repeat (100) @(negedge clk_sys);
    check(n_nz == 0 && n_zero > 0, 1'b1);
    // parity of a lone error in the first bit of a multiblock
    exp_syn = 26'h0220211;
    repeat (2047) exp_syn = {exp_syn[24:0], 1'b0} ^ ({26{exp_syn[25]}} & 26'h0220211);
    armed = 1'b1;
    repeat (100) if (!(blk_valid && blk_ready && blk_idx == 5'h1f)) @(negedge clk_sys);
    err_bit = 1'b1;
    inj_cyc = cyc;
    @(negedge clk_sys);
    err_bit = 1'b0;
    repeat (150) @(negedge clk_sys);
    check(n_nz, 1);
    armed = 1'b0;
    $display("test syndrome done");
    err_hdr = 1'b1;
    @(negedge clk_sys);
    err_hdr = 1'b0;
    repeat (100) @(negedge clk_sys);
    check(blk_lock, 1'b1);
    err_hdr = 1'b1;
    // a fixed window can split a burst, so errors go on until the lock drops
    repeat (10) if (blk_lock !== 1'b0) @(negedge clk_sys);
    err_hdr = 1'b0;
    repeat (4) @(negedge clk_sys);
    check(blk_lock | mb_lock, 1'b0);
    check(n_rr, 1);
    $display("test header done");
    repeat (1000) if (emb_lock !== 1'b1) @(negedge clk_sys);
    t0 = n_ref;
    err_pilot = 1'b1;
    repeat (150) if (mb_lock !== 1'b0) @(negedge clk_sys);
    err_pilot = 1'b0;
    check({blk_lock, mb_lock}, 2'b10);
    repeat (3) @(negedge clk_sys);
    check(n_ref > t0, 1'b1);
    repeat (1000) if (emb_lock !== 1'b1) @(negedge clk_sys);
    check(emb_lock, 1'b1);
    $display("test pilot done");
    t0 = n_ref;
    err_end_of_ext_multiblock_flag = 1'b1;
    repeat (150) if (emb_lock !== 1'b0) @(negedge clk_sys);
    err_end_of_ext_multiblock_flag = 1'b0;
    check({mb_lock, emb_lock}, 2'b10);
    repeat (3) @(negedge clk_sys);
    check(n_ref > t0, 1'b1);
    repeat (100) if (emb_lock !== 1'b1) @(negedge clk_sys);
    check(emb_lock, 1'b1);
    $display("test end_of_ext_multiblock_flag done");
    cmd_enable = 1'b0;
    repeat (3) @(negedge clk_sys);
    check({link_enable, blk_lock, mb_lock, released}, 4'h0);
    // restart without fec: no syndrome may be reported
    cmd_fec = 1'b0;
    cmd_enable = 1'b1;
    t0 = n_zero + n_nz;
    @(negedge clk_sys);
    check({link_enable, sync_header_mode_select}, 3'h4);
    repeat (300) @(negedge clk_sys);
    check({blk_lock, n_zero + n_nz == t0}, 2'b11);
    $display("test disable done");
    summarize;
  end
endmodule // shfl_rx_host_bench

// >>> dv/shfl_rx_host_checker.sv
/* port checks for shfl_rx_host.
   assumes bind into the host, one clock. */
`timescale 1ns/1ps
module shfl_rx_host_checker #(
  parameter PE_W  = 4,
  parameter RBD_W = 8
) (
  // clock and reset
  input wire             clk_sys,
  input wire             sys_rst,
  // commands and pins
  input wire             cmd_enable,
  input wire             cmd_fec,
  input wire [RBD_W-1:0] cmd_rbd,
  input wire             local_ext_multiblock_clock_tick,
  input wire             link_enable,
  input wire [1:0]       sync_header_mode_select,
  input wire [PE_W-1:0]  serializer_preemphasis_level,
  input wire             sysref_pulse,
  // status
  input wire             out_valid,
  input wire             blk_lock,
  input wire             mb_lock,
  input wire             emb_lock,
  input wire             released,
  input wire [25:0]      syndrome,
  input wire             syndrome_valid,
  input wire             realign_req
);
  reg [15:0] since_tick;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // cycles since the local clock edge, to pin the release offset
  always @(posedge clk_sys)
  begin
    since_tick <= (sys_rst || local_ext_multiblock_clock_tick) ? 16'h0 : since_tick + 16'h1;
  end
  a_enable_lag: assert property (link_enable == $past(cmd_enable))
    else $error("enable lag wrong");
  a_mode_taken: assert property ($rose(link_enable) |->
    sync_header_mode_select == ($past(cmd_fec) ? 2'h2 : 2'h0)) else $error("mode not latched");
  a_cfg_frozen: assert property (link_enable && $past(link_enable) |->
    $stable(sync_header_mode_select) && $stable(serializer_preemphasis_level)) else $error("cfg moved");
  a_ref_start: assert property ($rose(link_enable) |-> sysref_pulse)
    else $error("no start pulse");
  a_ref_loss: assert property ($fell(mb_lock) && blk_lock && link_enable |-> ##[0:2] sysref_pulse)
    else $error("no pulse after loss");
  a_syn_locked: assert property (syndrome_valid |-> $past(mb_lock) && sync_header_mode_select == 2'h2)
    else $error("syndrome unaligned");
  a_rel_point: assert property ($rose(released) |-> since_tick == 16'(cmd_rbd))
    else $error("release offset wrong");
  a_lock_chain: assert property (emb_lock |-> mb_lock && blk_lock)
    else $error("lock order wrong");
  a_out_gated: assert property (out_valid |-> released)
    else $error("data before release");
  a_hdr_drop: assert property ($rose(realign_req) |-> ##[0:1] !blk_lock)
    else $error("lock kept");
  a_off_quiet: assert property (!link_enable && !$past(link_enable) |->
    !blk_lock && !mb_lock && !released && !syndrome_valid) else $error("active while off");
  c_release: cover property ($rose(released));
  c_syn_err: cover property (syndrome_valid && syndrome != 26'h0);
  c_realign: cover property (realign_req);
endmodule // shfl_rx_host_checker
bind shfl_rx_host shfl_rx_host_checker #(.PE_W(PE_W), .RBD_W(RBD_W)) chk (
  .clk_sys, .sys_rst, .cmd_enable, .cmd_fec, .cmd_rbd, .local_ext_multiblock_clock_tick, .link_enable,
  .sync_header_mode_select, .serializer_preemphasis_level, .sysref_pulse, .out_valid,
  .blk_lock, .mb_lock, .emb_lock, .released, .syndrome, .syndrome_valid, .realign_req);

// >>> hw/shfl_fifo.v
/*
  flip-flop fifo with valid/ready on both sides and a synchronous clear.
  assumes one clock; depth is a power of two.
*/
`timescale 1ns/1ps
module shfl_fifo #(
  parameter W  = 64,
  parameter D  = 8,
  parameter AW = 3
) (
  // clock and reset
  input  wire         clk_sys,
  input  wire         sys_rst,
  input  wire         clr,
  // write side
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output wire         in_ready,
  // read side
  output wire         out_valid,
  output wire [W-1:0] out_data,
  input  wire         out_ready
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW:0]  wr_ptr;
  reg  [AW:0]  rd_ptr;
  wire         empty;
  wire         full;

  assign empty     = (wr_ptr == rd_ptr);
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always @(posedge clk_sys)
  begin
    if (in_valid && !full)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clk_sys)
  begin
    if (sys_rst || clr)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
      begin
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      end
      if (out_ready && !empty)
      begin
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // shfl_fifo

// >>> hw/shfl_rx_host.v
/*
  host-side receiver for one lane of a 64b/66b link in fec sync header mode:
  drives the device's enable, mode, pre-emphasis and reference pulse, checks
  sync header stream framing and fec syndromes, and releases the lane buffer.
  assumes blocks arrive block-aligned, one per accepted cycle, descrambled
  data excluded from nothing (parity runs on scrambled data as delivered).
*/
// What this block does
// - syndrome compare, zero means error free
// - confirm pilot over several multiblocks first
// - detection latency at least 58 blocks
// - align all, buffer from next emb start
// - release at local_ext_multiblock_clock edge plus delay
// - release point avoids arrival-variation region
// - header errors in window drop block lock
// - pilot errors in window drop mb lock
// - end_of_ext_multiblock_flag errors in window redo emb align
// - reference pulse restores local_ext_multiblock_clock after pilot or flag loss, not after a header drop
// - change link parameters only while disabled
// - reference pulse phases local_ext_multiblock_clock both ends; sysref_pulse here drives the device end only, local tick is an input
`timescale 1ns/1ps
`include "shfl_defs.vh"
module shfl_rx_host #(
  parameter       PE_W        = 4,
  parameter       RBD_W       = 8,
  parameter [7:0] EMB_E       = 8'h01,
  parameter [7:0] MB_CONFIRM  = 8'h03,
  parameter [7:0] HDR_WIN     = 8'h40,
  parameter [7:0] HDR_ERR_MAX = 8'h04,
  parameter [7:0] MB_WIN      = 8'h08,
  parameter [7:0] MB_ERR_MAX  = 8'h02,
  parameter [7:0] EMB_WIN     = 8'h08,
  parameter [7:0] EMB_ERR_MAX = 8'h02
) (
  // clock and reset
  input  wire                     clk_sys,
  input  wire                     sys_rst,
  // user commands
  input  wire                     cmd_enable,
  input  wire                     cmd_fec,
  input  wire [PE_W-1:0]          cmd_preemph,
  input  wire [RBD_W-1:0]         cmd_rbd,
  // device control pins
  output reg                      link_enable,
  output wire [1:0]               sync_header_mode_select,
  output reg  [PE_W-1:0]          serializer_preemphasis_level,
  output reg                      sysref_pulse,
  // local extended multiblock clock edge
  input  wire                     local_ext_multiblock_clock_tick,
  // lane blocks in
  input  wire                     blk_valid,
  input  wire [1:0]               blk_hdr,
  input  wire [`SHFL_DATA_W-1:0]  blk_data,
  output wire                     blk_ready,
  // released data out
  output wire                     out_valid,
  output wire [`SHFL_DATA_W-1:0]  out_data,
  input  wire                     out_ready,
  // status
  output reg                      blk_lock,
  output reg                      mb_lock,
  output reg                      emb_lock,
  output wire                     released,
  output reg  [`SHFL_PAR_W-1:0]   syndrome,
  output reg                      syndrome_valid,
  output reg                      fec_error,
  output reg                      realign_req
);
  reg                     cfg_fec;
  reg  [RBD_W-1:0]        cfg_rbd;
  reg  [31:0]             sh;
  reg  [4:0]              mb_cnt;
  reg  [`SHFL_PAR_W-1:0]  par_acc;
  reg  [`SHFL_PAR_W-1:0]  prev_par;
  reg                     par_have;
  reg  [7:0]              mb_conf;
  reg  [7:0]              hdr_win_cnt;
  reg  [7:0]              hdr_err_cnt;
  reg  [7:0]              mb_win_cnt;
  reg  [7:0]              mb_err_cnt;
  reg  [7:0]              emb_cnt;
  reg  [7:0]              emb_win_cnt;
  reg  [7:0]              emb_err_cnt;
  reg  [1:0]              st;
  reg                     rel_run;
  reg  [RBD_W-1:0]        rel_cnt;
  reg                     align_lost;
  wire                    rx_rst;
  wire                    acc;
  wire                    hdr_ok;
  wire [31:0]             next_sh;
  wire                    mb_end;
  wire                    pilot_ok;
  wire [`SHFL_PAR_W-1:0]  next_par;
  wire [`SHFL_PAR_W-1:0]  rx_par;
  wire                    end_of_ext_multiblock_flag;
  wire                    emb_last;
  wire [7:0]              hdr_err_sum;
  wire                    fifo_in_ready;
  wire                    fifo_out_valid;
  wire                    buffering;

  // serial lfsr unrolled over one block, msb of the data first
  function [`SHFL_PAR_W-1:0] fec_step;
    input [`SHFL_PAR_W-1:0]  s_in;
    input [`SHFL_DATA_W-1:0] d;
    integer                  i;
    reg   [`SHFL_PAR_W-1:0]  s;
    reg                      fb;
    begin
      s = s_in;
      for (i = `SHFL_DATA_W - 1; i >= 0; i = i - 1)
      begin
        fb = s[`SHFL_PAR_W-1] ^ d[i];
        s  = {s[`SHFL_PAR_W-2:0], 1'b0} ^ (fb ? `SHFL_POLY : {`SHFL_PAR_W{1'b0}});
      end
      fec_step = s;
    end
  endfunction

  // the device is held in reset while disabled, so the receiver follows it
  assign rx_rst    = sys_rst || !link_enable;
  assign buffering = (st == `SHFL_ST_BUF) || (st == `SHFL_ST_REL);
  // outside buffering blocks are consumed and dropped, so alignment never stalls
  assign blk_ready = buffering ? fifo_in_ready : 1'b1;
  assign acc       = blk_valid && blk_ready;
  assign hdr_ok    = blk_hdr[0] ^ blk_hdr[1];
  assign next_sh   = {sh[30:0], blk_hdr[1]};
  assign mb_end    = (mb_cnt == `SHFL_MB_LAST);
  assign pilot_ok  = (next_sh[4:0] == `SHFL_PILOT);
  assign next_par  = fec_step((mb_cnt == 5'h00) ? {`SHFL_PAR_W{1'b0}} : par_acc, blk_data);
  assign rx_par    = {next_sh[31:10], next_sh[8], next_sh[7:5]};
  assign end_of_ext_multiblock_flag     = next_sh[`SHFL_END_OF_EXT_MULTIBLOCK_FLAG_POS];
  assign emb_last  = (emb_cnt == EMB_E - 8'h01);
  assign hdr_err_sum = hdr_err_cnt + {7'h00, !hdr_ok};
  assign sync_header_mode_select = cfg_fec ? `SHFL_SHM_FEC : `SHFL_SHM_CRC;
  assign released  = (st == `SHFL_ST_REL);
  assign out_valid = fifo_out_valid && released;

  // link parameters latch only while the link is down
  always @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      link_enable                  <= 1'b0;
      cfg_fec                      <= 1'b0;
      cfg_rbd                      <= {RBD_W{1'b0}};
      serializer_preemphasis_level <= {PE_W{1'b0}};
      sysref_pulse                 <= 1'b0;
    end
    else
    begin
      link_enable <= cmd_enable;
      if (!link_enable)
      begin
        cfg_fec                      <= cmd_fec;
        cfg_rbd                      <= cmd_rbd;
        serializer_preemphasis_level <= cmd_preemph;
      end
      // phase the local_ext_multiblock_clock at start-up and again after pilot or flag framing loss
      sysref_pulse <= (cmd_enable && !link_enable) || align_lost;
    end
  end

  always @(posedge clk_sys)
  begin
    if (rx_rst)
    begin
      sh <= 32'h00000000;
      mb_cnt <= 5'h00;
      par_acc <= {`SHFL_PAR_W{1'b0}};
      prev_par <= {`SHFL_PAR_W{1'b0}};
      par_have <= 1'b0;
      mb_conf <= 8'h00;
      hdr_win_cnt <= 8'h00;
      hdr_err_cnt <= 8'h00;
      mb_win_cnt <= 8'h00;
      mb_err_cnt <= 8'h00;
      emb_cnt <= 8'h00;
      emb_win_cnt <= 8'h00;
      emb_err_cnt <= 8'h00;
      blk_lock <= 1'b0;
      mb_lock <= 1'b0;
      emb_lock <= 1'b0;
      syndrome <= {`SHFL_PAR_W{1'b0}};
      syndrome_valid <= 1'b0;
      fec_error <= 1'b0;
      realign_req <= 1'b0;
      align_lost <= 1'b0;
    end
    else
    begin
      syndrome_valid <= 1'b0;
      realign_req <= 1'b0;
      align_lost <= 1'b0;
      if (acc)
      begin
        sh <= next_sh;
        mb_cnt <= mb_cnt + 5'h01;
        par_acc <= next_par;
        // a lone bad header is tolerated; too many in a window drop everything
        if (hdr_err_sum >= HDR_ERR_MAX)
        begin
          blk_lock <= 1'b0;
          mb_lock <= 1'b0;
          emb_lock <= 1'b0;
          par_have <= 1'b0;
          mb_conf <= 8'h00;
          realign_req <= 1'b1;
          hdr_win_cnt <= 8'h00;
          hdr_err_cnt <= 8'h00;
        end
        else if (hdr_win_cnt == HDR_WIN - 8'h01)
        begin
          if (hdr_err_sum == 8'h00)
          begin
            blk_lock <= 1'b1;
          end
          hdr_win_cnt <= 8'h00;
          hdr_err_cnt <= 8'h00;
        end
        else
        begin
          hdr_win_cnt <= hdr_win_cnt + 8'h01;
          hdr_err_cnt <= hdr_err_sum;
        end
        if (mb_end)
        begin
          prev_par <= next_par;
        end
        // pilot may appear elsewhere in fec mode, so it must repeat in place
        // a header drop in this cycle wins over any lock gained in it
        if (!mb_lock && blk_lock && hdr_err_sum < HDR_ERR_MAX)
        begin
          if (pilot_ok && hdr_ok && mb_end && mb_conf != 8'h00)
          begin
            mb_conf <= mb_conf + 8'h01;
            if (mb_conf + 8'h01 >= MB_CONFIRM)
            begin
              mb_lock <= 1'b1;
              mb_win_cnt <= 8'h00;
              mb_err_cnt <= 8'h00;
            end
          end
          else if (pilot_ok && hdr_ok && mb_conf == 8'h00)
          begin
            mb_cnt <= 5'h00;
            mb_conf <= 8'h01;
          end
          else if (mb_end)
          begin
            mb_conf <= 8'h00;
          end
        end
        else if (mb_lock && mb_end && hdr_err_sum < HDR_ERR_MAX)
        begin
          par_have <= 1'b1;
          // first checked multiblock is never the device's zero-parity one
          if (par_have && cfg_fec)
          begin
            syndrome <= rx_par ^ prev_par;
            syndrome_valid <= 1'b1;
            fec_error <= |(rx_par ^ prev_par);
          end
          if (!pilot_ok && mb_err_cnt + 8'h01 >= MB_ERR_MAX)
          begin
            mb_lock <= 1'b0;
            emb_lock <= 1'b0;
            par_have <= 1'b0;
            mb_conf <= 8'h00;
            align_lost <= 1'b1;
          end
          else if (mb_win_cnt == MB_WIN - 8'h01)
          begin
            mb_win_cnt <= 8'h00;
            mb_err_cnt <= 8'h00;
          end
          else
          begin
            mb_win_cnt <= mb_win_cnt + 8'h01;
            mb_err_cnt <= mb_err_cnt + {7'h00, !pilot_ok};
          end
          if (!emb_lock && (pilot_ok || mb_err_cnt + 8'h01 < MB_ERR_MAX))
          begin
            if (end_of_ext_multiblock_flag)
            begin
              emb_cnt <= 8'h00;
              emb_lock <= 1'b1;
              emb_win_cnt <= 8'h00;
              emb_err_cnt <= 8'h00;
            end
          end
          else
          begin
            emb_cnt <= emb_last ? 8'h00 : emb_cnt + 8'h01;
            // flag wrong, early or missing at the true end counts as an error
            if (end_of_ext_multiblock_flag != emb_last && emb_err_cnt + 8'h01 >= EMB_ERR_MAX)
            begin
              emb_lock <= 1'b0;
              align_lost <= 1'b1;
            end
            else if (end_of_ext_multiblock_flag != emb_last)
            begin
              emb_err_cnt <= emb_err_cnt + 8'h01;
            end
            else if (emb_last && emb_win_cnt == EMB_WIN - 8'h01)
            begin
              emb_win_cnt <= 8'h00;
              emb_err_cnt <= 8'h00;
            end
            else if (emb_last)
            begin
              emb_win_cnt <= emb_win_cnt + 8'h01;
            end
          end
        end
      end
    end
  end

  // buffer start and release; single lane, so all lanes have arrived once this one has
  always @(posedge clk_sys)
  begin
    if (rx_rst || !emb_lock)
    begin
      st <= `SHFL_ST_IDLE;
      rel_run <= 1'b0;
      rel_cnt <= {RBD_W{1'b0}};
    end
    else
    begin
      case (st)
        `SHFL_ST_IDLE:
        begin
          st <= `SHFL_ST_WAIT;
        end
        `SHFL_ST_WAIT:
        begin
          if (acc && mb_end && emb_last && end_of_ext_multiblock_flag)
          begin
            st <= `SHFL_ST_BUF;
          end
        end
        `SHFL_ST_BUF:
        begin
          // the delay value must keep release out of the arrival-variation region
          if ((local_ext_multiblock_clock_tick || rel_run) && ((local_ext_multiblock_clock_tick ? {RBD_W{1'b0}} : rel_cnt) == cfg_rbd))
          begin
            st <= `SHFL_ST_REL;
            rel_run <= 1'b0;
          end
          else if (local_ext_multiblock_clock_tick)
          begin
            rel_run <= 1'b1;
            rel_cnt <= {{(RBD_W-1){1'b0}}, 1'b1};
          end
          else if (rel_run)
          begin
            rel_cnt <= rel_cnt + {{(RBD_W-1){1'b0}}, 1'b1};
          end
        end
        `SHFL_ST_REL:
        begin
          st <= `SHFL_ST_REL;
        end
        default:
        begin
          st <= `SHFL_ST_IDLE;
        end
      endcase
    end
  end

  shfl_fifo #(
    .W  (`SHFL_DATA_W),
    .D  (`SHFL_FIFO_DEPTH),
    .AW (3)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (rx_rst),
    .clr       (st == `SHFL_ST_IDLE || st == `SHFL_ST_WAIT),
    .in_valid  (blk_valid && buffering),
    .in_data   (blk_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (out_data),
    .out_ready (out_ready && released)
  );
endmodule // shfl_rx_host
